//--- verilog/dcf_cfg.svh
// dcf_cfg.svh: offsets, field positions, reset values and latency counts of the fifo block
// assumes: included by dcf_pkg and dcf_top, macros are global to the compile
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
// ***************************************************
// storage geometry
// ***************************************************
`define DCF_DW 36
`define DCF_AW 6
`define DCF_PW 7
`define DCF_DEPTH 64
`define DCF_FULL_CNT 7'h40
`define DCF_HW 9
`define DCF_TW 6
// ***************************************************
// register byte offsets and fields
// ***************************************************
`define DCF_CTRL_OFF 8'h00
`define DCF_AE_OFF 8'h04
`define DCF_AF_OFF 8'h08
`define DCF_STAT_OFF 8'h0c
`define DCF_MARK_OFF 8'h10
`define DCF_CTRL_MB_BIT 0
`define DCF_CTRL_MARK_BIT 1
`define DCF_STAT_FLG_LSB 0
`define DCF_STAT_BUSY_BIT 4
`define DCF_STAT_CNT_LSB 8
`define DCF_CFG_AF_LSB 16
`define DCF_AE_RST 7'h08
`define DCF_AF_RST 7'h08
// ***************************************************
// latencies in clock cycles
// ***************************************************
`define DCF_LAT_EF_SET 0
`define DCF_LAT_EF_CLR 3
`define DCF_LAT_FF_SET 4
`define DCF_LAT_FF_CLR 8
`define DCF_LAT_AE_SET 7
`define DCF_LAT_AE_CLR 5
`define DCF_LAT_AF_SET 5
`define DCF_LAT_AF_CLR 7
`define DCF_LAT_PRS 32
`define DCF_LAT_MB 2
`define DCF_LAT_RD 4
`define DCF_LAT_RT 17
`endif

//--- verilog/dcf_pkg.sv
// dcf_pkg: types shared by the fifo block and its surroundings
// assumes: dcf_cfg.svh is on the include path
package dcf_pkg;
`include "dcf_cfg.svh"
    // ***************************************************
    // control states
    // ***************************************************
    typedef enum logic [1:0] {ST_RUN, ST_PRS, ST_RECOVER, ST_RETX} dcf_state_t;
    // ***************************************************
    // port carriers
    // ***************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dcf_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcf_apb_rsp_t;
    typedef struct packed {
        logic wr_en_n;
        logic [`DCF_DW-1:0] wr_data;
    } dcf_wr_t;
    typedef struct packed {
        logic rd_valid;
        logic [`DCF_DW-1:0] rd_data;
    } dcf_rd_t;
    typedef struct packed {
        logic full_flag;
        logic empty_flag;
        logic almost_full_flag;
        logic almost_empty_flag;
    } dcf_flags_t;
    // ***************************************************
    // whole state of the top module except the storage array
    // ***************************************************
    typedef struct packed {
        dcf_state_t st;
        logic [`DCF_TW-1:0] tmr;
        logic [`DCF_PW-1:0] wptr;
        logic [`DCF_PW-1:0] rptr;
        logic [`DCF_PW-1:0] mark;
        logic [`DCF_HW-1:0] ef_h;
        logic [`DCF_HW-1:0] ae_h;
        logic [`DCF_HW-1:0] af_h;
        logic [`DCF_HW-1:0] ff_h;
        logic ef_n;
        logic ae_n;
        logic af_n;
        logic ff_n;
        logic mb;
        logic [`DCF_PW-1:0] ae_thr;
        logic [`DCF_PW-1:0] af_thr;
        logic [`DCF_LAT_RD-1:0][`DCF_DW-1:0] pipe;
        logic [`DCF_LAT_RD-1:0] pv;
        logic [`DCF_DW-1:0] rd_data;
        logic rd_valid;
        logic [31:0] prdata;
    } dcf_regs_t;
endpackage : dcf_pkg

//--- verilog/dcf_top.sv
// dcf_top: fifo with latency-timed active-low flags, mailbox path, config read and retransmit
// assumes: writer and reader run on ref_clk (clock ratio one); an apb master owns the registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_top
(
    input wire ref_clk,
    input wire sys_rst,
    input dcf_pkg::dcf_apb_req_t apb_req,
    output dcf_pkg::dcf_apb_rsp_t apb_rsp,
    input dcf_pkg::dcf_wr_t wr_port,
    input wire rd_en_n,
    input wire config_load_n,
    input wire partial_reset_n,
    input wire retransmit_n,
    output dcf_pkg::dcf_rd_t rd_port,
    output dcf_pkg::dcf_flags_t flags
);
    // ***************************************************
    // declarations
    // ***************************************************
    dcf_pkg::dcf_regs_t s_reg;
    dcf_pkg::dcf_regs_t s_next;
    logic [`DCF_DW-1:0] mem [0:`DCF_DEPTH-1];
    logic [`DCF_PW-1:0] fill;
    logic [`DCF_PW-1:0] fill_next;
    logic [`DCF_DW-1:0] head_word;
    logic [`DCF_DW-1:0] cfg_word;
    logic run, wr_take, mb_take, cfg_wr, rd_take, cfg_rd, rt_take, peek;
    logic apb_wr, apb_setup, addr_ok;
    logic c_ef, c_ae, c_af, c_ff;

    // fill level from pointers that carry one wrap bit
    function automatic logic [`DCF_PW-1:0] fill_of(input logic [`DCF_PW-1:0] w, input logic [`DCF_PW-1:0] r);
        return w - r;
    endfunction : fill_of

    // condition history, bit n holds the condition as it stood n edges ago
    function automatic logic [`DCF_HW-1:0] hist_push(input logic [`DCF_HW-1:0] h, input logic c, input logic ld);
        return ld ? {`DCF_HW{c}} : {h[`DCF_HW-2:0], c};
    endfunction : hist_push

    // active-low flag: set and clear each seen through their own delay tap
    function automatic logic flag_n(input logic [`DCF_HW-1:0] h, input int set_lat, input int clr_lat);
        logic hit;
        hit = (set_lat <= clr_lat) ? (h[set_lat] | h[clr_lat]) : (h[set_lat] & h[clr_lat]);
        return !hit;
    endfunction : flag_n

    // ***************************************************
    // request decode
    // ***************************************************
    // partial reset and the recovery or retransmit windows shut the write, read and retransmit ports; the apb port stays open
    assign run = (s_reg.st == dcf_pkg::ST_RUN) && partial_reset_n;
    assign fill = fill_of(s_reg.wptr, s_reg.rptr);
    assign rt_take = run && !retransmit_n;
    assign mb_take = run && !wr_port.wr_en_n && s_reg.mb;
    assign cfg_wr = run && !wr_port.wr_en_n && !s_reg.mb && !config_load_n;
    // a write to a full buffer is dropped silently
    assign wr_take = run && !wr_port.wr_en_n && !s_reg.mb && config_load_n && (fill != `DCF_FULL_CNT);
    // reads pause in mailbox mode so the two paths never collide in the pipe
    assign cfg_rd = run && retransmit_n && !rd_en_n && !config_load_n && !s_reg.mb;
    assign rd_take = run && retransmit_n && !rd_en_n && config_load_n && !s_reg.mb && s_reg.ef_n && (fill != '0);
    // last retransmit cycle fetches the marked word without popping it
    assign peek = (s_reg.st == dcf_pkg::ST_RETX) && (s_reg.tmr == '0) && !s_reg.mb;
    assign head_word = mem[s_reg.rptr[`DCF_AW-1:0]];
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign apb_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign addr_ok = apb_req.paddr inside {`DCF_CTRL_OFF, `DCF_AE_OFF, `DCF_AF_OFF, `DCF_STAT_OFF, `DCF_MARK_OFF};

    // configuration word as seen on the read port
    always_comb
    begin
        cfg_word = '0;
        cfg_word[`DCF_PW-1:0] = s_reg.ae_thr;
        cfg_word[`DCF_CFG_AF_LSB +: `DCF_PW] = s_reg.af_thr;
    end

    // ***************************************************
    // next state
    // ***************************************************
    always_comb
    begin
        s_next = s_reg;
        // read pipeline shifts every cycle; empty slots carry valid low
        s_next.pipe = {s_reg.pipe[`DCF_LAT_RD-2:0], head_word};
        s_next.pv = {s_reg.pv[`DCF_LAT_RD-2:0], 1'b0};
        s_next.rd_valid = s_reg.pv[`DCF_LAT_RD-1];
        if (s_reg.pv[`DCF_LAT_RD-1])
        begin
            s_next.rd_data = s_reg.pipe[`DCF_LAT_RD-1];
        end
        if (rd_take || peek)
        begin
            s_next.pv[0] = 1'b1;
        end
        if (cfg_rd)
        begin
            s_next.pipe[0] = cfg_word;
            s_next.pv[0] = 1'b1;
        end
        // mailbox enters late in the pipe so it needs fewer stages
        if (mb_take)
        begin
            s_next.pipe[`DCF_LAT_RD-`DCF_LAT_MB] = wr_port.wr_data;
            s_next.pv[`DCF_LAT_RD-`DCF_LAT_MB] = 1'b1;
        end
        // pointer moves
        if (wr_take)
        begin
            s_next.wptr = s_reg.wptr + 7'h01;
        end
        if (rd_take)
        begin
            s_next.rptr = s_reg.rptr + 7'h01;
        end
        // write with config load low sets both boundaries
        if (cfg_wr)
        begin
            s_next.ae_thr = wr_port.wr_data[`DCF_PW-1:0];
            s_next.af_thr = wr_port.wr_data[`DCF_CFG_AF_LSB +: `DCF_PW];
        end
        // register writes
        if (apb_wr)
        begin
            case (apb_req.paddr)
                `DCF_CTRL_OFF:
                begin
                    s_next.mb = apb_req.pwdata[`DCF_CTRL_MB_BIT];
                    if (apb_req.pwdata[`DCF_CTRL_MARK_BIT])
                    begin
                        s_next.mark = s_reg.rptr;
                    end
                end
                `DCF_AE_OFF: s_next.ae_thr = apb_req.pwdata[`DCF_PW-1:0];
                `DCF_AF_OFF: s_next.af_thr = apb_req.pwdata[`DCF_PW-1:0];
                default: s_next.mb = s_reg.mb;
            endcase
        end
        // register reads are captured in the setup phase, so no wait state
        if (apb_setup)
        begin
            s_next.prdata = '0;
            case (apb_req.paddr)
                `DCF_CTRL_OFF: s_next.prdata[`DCF_CTRL_MB_BIT] = s_reg.mb;
                `DCF_AE_OFF: s_next.prdata[`DCF_PW-1:0] = s_reg.ae_thr;
                `DCF_AF_OFF: s_next.prdata[`DCF_PW-1:0] = s_reg.af_thr;
                `DCF_STAT_OFF:
                begin
                    s_next.prdata[`DCF_STAT_FLG_LSB +: 4] = {s_reg.ff_n, s_reg.af_n, s_reg.ae_n, s_reg.ef_n};
                    s_next.prdata[`DCF_STAT_BUSY_BIT] = !run;
                    s_next.prdata[`DCF_STAT_CNT_LSB +: `DCF_PW] = fill;
                end
                `DCF_MARK_OFF: s_next.prdata[`DCF_PW-1:0] = s_reg.mark;
                default: s_next.prdata = '0;
            endcase
        end
        // control sequence
        unique case (s_reg.st)
            dcf_pkg::ST_RUN:
            begin
                if (rt_take)
                begin
                    s_next.rptr = s_reg.mark;
                    s_next.st = dcf_pkg::ST_RETX;
                    s_next.tmr = `DCF_TW'(`DCF_LAT_RT - 2);
                end
            end
            dcf_pkg::ST_RETX:
            begin
                if (s_reg.tmr == '0)
                begin
                    s_next.st = dcf_pkg::ST_RUN;
                end
                else
                begin
                    s_next.tmr = s_reg.tmr - 6'h01;
                end
            end
            dcf_pkg::ST_PRS:
            begin
                if (partial_reset_n)
                begin
                    s_next.st = dcf_pkg::ST_RECOVER;
                    s_next.tmr = `DCF_TW'(`DCF_LAT_PRS - 1);
                end
            end
            dcf_pkg::ST_RECOVER:
            begin
                if (s_reg.tmr == '0)
                begin
                    s_next.st = dcf_pkg::ST_RUN;
                end
                else
                begin
                    s_next.tmr = s_reg.tmr - 6'h01;
                end
            end
        endcase
        // partial reset empties the buffer but keeps the boundaries
        if (!partial_reset_n)
        begin
            s_next.st = dcf_pkg::ST_PRS;
            s_next.wptr = '0;
            s_next.rptr = '0;
            s_next.mark = '0;
        end
        // flag conditions from the new fill level
        fill_next = fill_of(s_next.wptr, s_next.rptr);
        c_ef = (fill_next == '0);
        c_ae = (fill_next <= s_next.ae_thr);
        c_af = (fill_next >= (`DCF_FULL_CNT - s_next.af_thr));
        c_ff = (fill_next == `DCF_FULL_CNT);
        // retransmit and partial reset reload history, so flags settle at once
        s_next.ef_h = hist_push(s_reg.ef_h, c_ef, rt_take || !partial_reset_n);
        s_next.ae_h = hist_push(s_reg.ae_h, c_ae, rt_take || !partial_reset_n);
        s_next.af_h = hist_push(s_reg.af_h, c_af, rt_take || !partial_reset_n);
        s_next.ff_h = hist_push(s_reg.ff_h, c_ff, rt_take || !partial_reset_n);
        // equal clocks assumed: the taps count ref_clk for both sides
        s_next.ef_n = flag_n(s_next.ef_h, `DCF_LAT_EF_SET, `DCF_LAT_EF_CLR);
        s_next.ae_n = flag_n(s_next.ae_h, `DCF_LAT_AE_SET, `DCF_LAT_AE_CLR);
        s_next.af_n = flag_n(s_next.af_h, `DCF_LAT_AF_SET, `DCF_LAT_AF_CLR);
        s_next.ff_n = flag_n(s_next.ff_h, `DCF_LAT_FF_SET, `DCF_LAT_FF_CLR);
    end

    // ***************************************************
    // registers
    // ***************************************************
    // reset leaves an empty buffer: empty and almost-empty asserted
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.ef_h <= '1;
            s_reg.ae_h <= '1;
            s_reg.af_n <= 1'b1;
            s_reg.ff_n <= 1'b1;
            s_reg.ae_thr <= `DCF_AE_RST;
            s_reg.af_thr <= `DCF_AF_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // storage array has no reset; apart from the retransmit peek, words are only read once written
    always_ff @(posedge ref_clk)
    begin
        if (wr_take)
        begin
            mem[s_reg.wptr[`DCF_AW-1:0]] <= wr_port.wr_data;
        end
    end

    // outputs
    assign flags = '{full_flag: s_reg.ff_n, empty_flag: s_reg.ef_n,
                     almost_full_flag: s_reg.af_n, almost_empty_flag: s_reg.ae_n};
    assign rd_port = '{rd_valid: s_reg.rd_valid, rd_data: s_reg.rd_data};
    assign apb_rsp = '{prdata: s_reg.prdata, pready: 1'b1,
                       pslverr: apb_req.psel && apb_req.penable && !addr_ok};

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst || !partial_reset_n);

    property p_ff_set;
        $rose(s_reg.ff_h[0]) |-> ##[1:4] !flags.full_flag;
    endproperty
    a_ff_set: assert property (p_ff_set) else $error("full flag late");
    property p_ef_set;
        $rose(s_reg.ef_h[0]) |-> !flags.empty_flag;
    endproperty
    a_ef_set: assert property (p_ef_set) else $error("empty flag not immediate");
    property p_prs_wait;
        $rose(partial_reset_n) && s_reg.st == dcf_pkg::ST_PRS |=> (s_reg.st == dcf_pkg::ST_RECOVER)[*8]
            ##1 (s_reg.st == dcf_pkg::ST_RECOVER)[*8] ##1 (s_reg.st == dcf_pkg::ST_RECOVER)[*8]
            ##1 (s_reg.st == dcf_pkg::ST_RECOVER)[*8] ##1 s_reg.st == dcf_pkg::ST_RUN;
    endproperty
    a_prs_wait: assert property (p_prs_wait) else $error("recovery not 32 cycles");
    property p_mbox;
        mb_take |-> ##3 rd_port.rd_valid && rd_port.rd_data == $past(wr_port.wr_data, 3);
    endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox latency");
    property p_rd_lat;
        rd_take |-> ##5 rd_port.rd_valid && rd_port.rd_data == $past(head_word, 5);
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read latency");
    property p_cfg_lat;
        cfg_rd |-> ##5 rd_port.rd_valid && rd_port.rd_data == $past(cfg_word, 5);
    endproperty
    a_cfg_lat: assert property (p_cfg_lat) else $error("config read latency");
    property p_ae_clr;
        $fell(s_reg.ae_h[0]) && !flags.almost_empty_flag |-> !flags.almost_empty_flag[*5]
            ##1 flags.almost_empty_flag;
    endproperty
    a_ae_clr: assert property (p_ae_clr) else $error("almost-empty rise not 5");
    property p_af_set;
        $rose(s_reg.af_h[0]) && flags.almost_full_flag |-> flags.almost_full_flag[*5] ##1 !flags.almost_full_flag;
    endproperty
    a_af_set: assert property (p_af_set) else $error("almost-full fall not 5");
    property p_ae_set;
        $rose(s_reg.ae_h[0]) && flags.almost_empty_flag |-> flags.almost_empty_flag[*7]
            ##1 !flags.almost_empty_flag;
    endproperty
    a_ae_set: assert property (p_ae_set) else $error("almost-empty fall not 7");
    property p_af_clr;
        $fell(s_reg.af_h[0]) && !flags.almost_full_flag |-> !flags.almost_full_flag[*7] ##1 flags.almost_full_flag;
    endproperty
    a_af_clr: assert property (p_af_clr) else $error("almost-full rise not 7");
    property p_ff_clr;
        $fell(s_reg.ff_h[0]) && !flags.full_flag |-> !flags.full_flag[*8] ##1 flags.full_flag;
    endproperty
    a_ff_clr: assert property (p_ff_clr) else $error("full release not 8");
    property p_rt_flags;
        rt_take |=> flags.empty_flag == (fill != '0) && flags.full_flag == (fill != `DCF_FULL_CNT);
    endproperty
    a_rt_flags: assert property (p_rt_flags) else $error("flags stale after retransmit");
    property p_rt_data;
        rt_take && !s_reg.mb && fill_of(s_reg.wptr, s_reg.mark) != '0 |-> ##[1:21] rd_port.rd_valid;
    endproperty
    a_rt_data: assert property (p_rt_data) else $error("no data after retransmit");
    property p_first_word;
        $fell(s_reg.ef_h[0]) |-> ##[1:26] flags.empty_flag;
    endproperty
    a_first_word: assert property (p_first_word) else $error("new data not readable");
    property p_ef_clr;
        $fell(s_reg.ef_h[0]) && !flags.empty_flag |-> !flags.empty_flag[*3] ##1 flags.empty_flag;
    endproperty
    a_ef_clr: assert property (p_ef_clr) else $error("empty release late");
    property p_rt_ff;
        rt_take && fill_of(s_reg.wptr, s_reg.mark) != `DCF_FULL_CNT |-> ##[1:6] flags.full_flag;
    endproperty
    a_rt_ff: assert property (p_rt_ff) else $error("full not released in retransmit");

    c_mbox: cover property (mb_take ##3 rd_port.rd_valid);
    c_cfg: cover property (cfg_rd ##5 rd_port.rd_valid);
    c_retx: cover property (rt_take ##21 rd_port.rd_valid);
    c_full: cover property ($fell(flags.full_flag));
endmodule : dcf_top

//--- verification/dcf_far_model.sv
// dcf_far_model: writer and reader logic facing the fifo ports
// assumes: the bench calls xfer; one clock is shared with the fifo
`timescale 1ns/1ps
module dcf_far_model
(
    input wire ref_clk,
    input wire partial_reset_n,
    input wire retransmit_n,
    output dcf_pkg::dcf_wr_t wr,
    output logic rd_en_n,
    output logic config_load_n
);
    int hold = 0;
    initial
    begin
        wr = '{wr_en_n: 1'b1, wr_data: 36'h0};
        rd_en_n = 1'b1;
        config_load_n = 1'b1;
    end
    // quiet spans after partial reset and retransmit, one and two edges longer than needed
    always @(posedge ref_clk)
        if (!partial_reset_n) hold <= 33;
        else if (!retransmit_n) hold <= 17;
        else if (hold > 0) hold <= hold - 1;
    // one write or read per call, held across exactly one taking edge
    task xfer(input logic rd, input logic [35:0] d, input logic cfg);
        do @(posedge ref_clk); while (hold != 0);
        rd_en_n <= ~rd;
        wr <= '{wr_en_n: rd, wr_data: d};
        config_load_n <= ~cfg;
        @(posedge ref_clk);
        rd_en_n <= 1'b1;
        wr <= '{wr_en_n: 1'b1, wr_data: ~d}; // released data never shows the stale word
        config_load_n <= 1'b1;
    endtask : xfer
endmodule : dcf_far_model

//--- verification/tb_top.sv
// tb_top: self-checking bench for the fifo latency block
// assumes: dcf_top and dcf_far_model compiled before it, one 25 MHz clock
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic partial_reset_n = 1'b1;
    logic retransmit_n = 1'b1;
    logic rd_en_n;
    logic config_load_n;
    dcf_pkg::dcf_apb_req_t apb_req = '0;
    dcf_pkg::dcf_apb_rsp_t apb_rsp;
    dcf_pkg::dcf_wr_t wr_port;
    dcf_pkg::dcf_rd_t rd_port;
    dcf_pkg::dcf_flags_t flags;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    logic [31:0] seed = 32'h0000acb3;
    logic [31:0] rv;
    logic e;
    logic [35:0] d;
    logic [35:0] d2;
    logic [35:0] exp_q[$];
    dcf_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .wr_port(wr_port), .rd_en_n(rd_en_n), .config_load_n(config_load_n),
        .partial_reset_n(partial_reset_n), .retransmit_n(retransmit_n), .rd_port(rd_port), .flags(flags));
    dcf_far_model u_far (.ref_clk(ref_clk), .partial_reset_n(partial_reset_n), .retransmit_n(retransmit_n),
        .wr(wr_port), .rd_en_n(rd_en_n), .config_load_n(config_load_n));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    // xorshift draw; the fixed start value keeps every run alike
    function automatic logic [35:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {seed[3:0], seed};
    endfunction : rnd
    function automatic logic [35:0] cfg_word(input logic [6:0] ae, input logic [6:0] af);
        return {13'h0, af, 9'h0, ae};
    endfunction : cfg_word
    // apb master: setup, access until pready, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
        rv = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        #1;
    endtask : apb
    // edges until bit b of {rd_valid, flags} reads v; bounded so a dead flag cannot hang
    task lat(input int b, input logic v);
        logic [4:0] s;
        n = 0;
        s = {rd_port.rd_valid, flags};
        while (s[b] !== v && n < 40)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            s = {rd_port.rd_valid, flags};
        end
    endtask : lat
    // every delivered word must be the oldest one still expected
    always @(posedge ref_clk)
    begin
        #1;
        if (rd_port.rd_valid === 1'b1)
            chk(rd_port.rd_data, exp_q.size() != 0 ? exp_q.pop_front() : ~rd_port.rd_data);
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        chk(flags, 36'ha);
        apb(1'b0, 8'h04, 32'h0);
        chk(rv, 36'h8);
        apb(1'b0, 8'h14, 32'h0);
        chk(e, 1'b1);
        d = rnd();
        exp_q.push_back(d);
        u_far.xfer(1'b0, d, 1'b0);
        #1;
        lat(2, 1'b1);
        chk(n, 36'h3);
        u_far.xfer(1'b1, d, 1'b0);
        #1;
        chk(flags.empty_flag, 1'b0);
        lat(4, 1'b1);
        chk(n, 36'h4);
        // fill to full plus one refused write
        for (int i = 1; i <= 65; i++)
        begin
            d = rnd();
            if (i < 65) exp_q.push_back(d);
            u_far.xfer(1'b0, d, 1'b0);
            #1;
            if (i == 9 || i == 56)
            begin
                lat(i == 9 ? 0 : 1, i == 9);
                chk(n, 36'h5);
            end
            if (i == 64)
            begin
                lat(3, 1'b0);
                chk(n <= 4, 1'b1);
            end
        end
        // drain while timing the full and almost-full releases and the almost-empty set
        for (int j = 1; j <= 64; j++)
        begin
            u_far.xfer(1'b1, d, 1'b0);
            #1;
            if (j == 1 || j == 9 || j == 56)
            begin
                lat(j == 1 ? 3 : (j == 9 ? 1 : 0), j < 56);
                chk(n, j == 1 ? 36'h8 : 36'h7);
            end
        end
        chk(flags.empty_flag, 1'b0);
        // the last drained word is still in the pipe; let it leave before timing the config read
        repeat (4) @(posedge ref_clk);
        u_far.xfer(1'b0, cfg_word(7'h0a, 7'h0c), 1'b1);
        exp_q.push_back(cfg_word(7'h0a, 7'h0c));
        u_far.xfer(1'b1, d, 1'b1);
        #1;
        lat(4, 1'b1);
        chk(n, 36'h4);
        apb(1'b0, 8'h08, 32'h0);
        chk(rv, 36'hc);
        apb(1'b1, 8'h00, 32'h1);
        d = rnd();
        exp_q.push_back(d);
        u_far.xfer(1'b0, d, 1'b0);
        #1;
        lat(4, 1'b1);
        chk(n, 36'h2);
        apb(1'b1, 8'h00, 32'h0);
        // partial reset throws away a stored word and blocks for a while
        u_far.xfer(1'b0, 36'h0, 1'b0);
        partial_reset_n <= 1'b0;
        @(posedge ref_clk);
        partial_reset_n <= 1'b1;
        apb(1'b0, 8'h0c, 32'h0);
        chk(rv[4], 1'b1);
        u_far.xfer(1'b0, d, 1'b0);
        exp_q.push_back(d);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rv[14:8], 36'h1);
        apb(1'b1, 8'h00, 32'h2);
        d2 = rnd();
        exp_q.push_back(d2);
        u_far.xfer(1'b0, d2, 1'b0);
        u_far.xfer(1'b1, d, 1'b0);
        u_far.xfer(1'b1, d, 1'b0);
        repeat (6) @(posedge ref_clk);
        retransmit_n <= 1'b0;
        @(posedge ref_clk);
        retransmit_n <= 1'b1;
        exp_q.push_back(d);
        exp_q.push_back(d);
        exp_q.push_back(d2);
        #1;
        chk(flags.empty_flag, 1'b1);
        lat(4, 1'b1);
        chk(n, 36'h14);
        u_far.xfer(1'b1, d, 1'b0);
        u_far.xfer(1'b1, d, 1'b0);
        repeat (8) @(posedge ref_clk);
        chk(exp_q.size(), 36'h0);
        tally_and_finish();
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // watchdog far above the roughly 430 cycles the sequence needs
    initial
    begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
